// ==== hw/ffi_pkg.sv ====
package ffi_pkg;
   localparam int unsigned WORD_W = 48;
   localparam int unsigned NUM_CHAN = 4;
   // Flag bit positions in the fault flag register
   localparam int unsigned BIT_SHIFT = 1;
   localparam int unsigned BIT_DIVIDE = 2;
   localparam int unsigned BIT_FIXOVF = 3;
   localparam int unsigned BIT_EXPOVF = 4;
   localparam int unsigned BIT_EXPUNF = 5;
   localparam int unsigned BIT_IOPAR0 = 20;
   localparam int unsigned BIT_BOUNDS = 42;
   localparam int unsigned BIT_MANUAL = 43;
   localparam int unsigned BIT_OPPAR = 45;
   localparam int unsigned BIT_INSPAR = 46;
   // Fault thresholds
   localparam logic [7:0] SHIFT_MAX_SINGLE = 8'h30;
   localparam logic [7:0] SHIFT_MAX_DOUBLE = 8'h60;
   localparam int unsigned EXP_W = 12;
   localparam logic signed [EXP_W-1:0] EXP_LIMIT = 12'sh3ff;
   localparam int unsigned MAG_LIMIT_BIT = 47;
   localparam logic [WORD_W-1:0] FLAGS_RESET = 48'h0;

   // Internal-function clear commands, one bit each
   typedef struct packed {
      logic arith;
      logic shift;
      logic divide;
      logic expovf;
      logic expunf;
      logic fixovf;
      logic iopar;
      logic parity;
      logic manual_sel;
      logic manual_clr;
      logic bounds_mask_clr;
      logic bounds_mask_set;
      logic intsys;
   } ffi_clear_t;

   // Operation results reported by the arithmetic and shift units
   typedef struct packed {
      logic shift_req;
      logic shift_double;
      logic [7:0] shift_count;
      logic fix_addsub;
      logic [WORD_W:0] fix_sum;
      logic int_div;
      logic [WORD_W:0] int_quot;
      logic div_zero;
      logic flt_div_coef_big;
      logic flt_op;
      logic signed [EXP_W-1:0] flt_exp;
      logic flt_coef_in_nz;
      logic flt_coef_res_z;
   } ffi_arith_t;

   // Storage and bounds events
   typedef struct packed {
      logic operand_par_err;
      logic instr_par_err;
      logic [NUM_CHAN-1:0] io_par_err;
      logic write_ref;
      logic jump_ref;
      logic fetch_ref;
      logic [7:0] ref_addr_hi;
      logic [7:0] lower_bound;
      logic [7:0] upper_bound;
   } ffi_mem_t;

   typedef struct packed {
      logic shift;
      logic divide;
      logic expovf;
      logic expunf;
      logic fixovf;
      logic oppar;
   } ffi_lamps_t;
endpackage

// ==== hw/ffi_flags.sv ====
// Summary of operation
// RL1: Single shift over 48 or double shift over 96 places sets flag bit 1.
// RL2: A shift count fault suppresses the shift entirely.
// RL3: Shift flag clears on arith, shift or system clear, or master clear.
// RL4: Divide flag bit 2 on big quotient, zero divisor or big coefficient.
// RL5: Arithmetic flags clear on group, own or system clear, or master clear.
// RL6: Exponent above 2^10-1 in floating ops sets flag bit 4.
// RL7: Exponent overflow leaves the formed result untouched.
// RL8: Zero result from nonzero inputs on overflow keeps residue, sets bit 4.
// RL9: Exponent below -(2^10-1) in floating ops sets flag bit 5.
// RL10: Exponent underflow clears both arithmetic registers to positive zero.
// RL11: Zero result from nonzero inputs masks underflow flag and lamp.
// RL12: Fixed sum or difference magnitude at least 2^47 sets flag bit 3.
// RL13: Channel parity error sets bits 20-23; cleared by I/O or system clear.
// RL14: Operand parity error sets bit 45; cleared by parity or system clear.
// RL15: Instruction parity error sets bit 46; same clears as bit 45.
// RL16: Manual interrupt switch sets bit 43 only when mask bit 43 is set.
// RL17: Manual flag clears on select, clear, system clear or master clear.
// RL18: Out-of-bounds reference with system active and mask 42 sets bit 42.
// RL19: Bounds flag clears on mask clear, redundant mask set, system clear.
// RL20: Console lamps for shift, divide, overflows and operand parity.
// RL21: Faults are recorded while execution continues; no halt is raised.
// RL22: Manual switch forces interrupt only with mask set and system active.
// RL23: Channel n maps to flag bit 20 plus n.
// RL24: A set and a clear in the same cycle leave the flag set.
`timescale 1ns/10ps
`default_nettype none
module ffi_flags (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Console
   input wire logic master_clear_i,
   input wire logic manual_switch_i,
   // Interrupt system state
   input wire logic intsys_active_i,
   input wire logic [ffi_pkg::WORD_W-1:0] mask_i,
   // Unit reports
   input wire ffi_pkg::ffi_arith_t arith_i,
   input wire ffi_pkg::ffi_mem_t mem_i,
   input wire ffi_pkg::ffi_clear_t clear_i,
   // Results to the processor
   output logic [ffi_pkg::WORD_W-1:0] fault_flag_register_o,
   output logic shift_inhibit_o,
   output logic regs_zero_o,
   output logic manual_irq_o,
   output logic halt_o,
   output ffi_pkg::ffi_lamps_t lamps_o
);
   typedef struct packed {
      logic [ffi_pkg::WORD_W-1:0] flags;
      logic shift_inhibit;
      logic regs_zero;
      logic manual_irq;
      logic halt;
      ffi_pkg::ffi_lamps_t lamps;
   } ffi_state_t;

   logic [1:0] rst_sync;
   logic rst_n;
   ffi_state_t st;
   ffi_state_t next_st;

   // Reset released through two flops, asserted at once
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   default clocking ffi_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   logic shift_fault, div_fault, exp_ovf, exp_unf_raw, exp_unf, fix_ovf;
   logic oob, residue_case, mag_quot, mag_sum;
   logic [ffi_pkg::WORD_W-1:0] set_v, clr_v;
   logic [7:0] shift_max;
   logic [ffi_pkg::WORD_W:0] abs_q, abs_s;

   always_comb begin
      shift_max = arith_i.shift_double ? ffi_pkg::SHIFT_MAX_DOUBLE
                                       : ffi_pkg::SHIFT_MAX_SINGLE;
      shift_fault = arith_i.shift_req &&
                    (arith_i.shift_count > shift_max); // RL1
      abs_q = arith_i.int_quot[ffi_pkg::WORD_W] ? -arith_i.int_quot
                                                : arith_i.int_quot;
      abs_s = arith_i.fix_sum[ffi_pkg::WORD_W] ? -arith_i.fix_sum
                                               : arith_i.fix_sum;
      // Any bit at or above 47 means magnitude reached 2^47
      mag_quot = |abs_q[ffi_pkg::WORD_W:ffi_pkg::MAG_LIMIT_BIT];
      mag_sum = |abs_s[ffi_pkg::WORD_W:ffi_pkg::MAG_LIMIT_BIT];
      div_fault = (arith_i.int_div && mag_quot) || arith_i.div_zero ||
                  arith_i.flt_div_coef_big; // RL4
      exp_ovf = arith_i.flt_op &&
                (arith_i.flt_exp > ffi_pkg::EXP_LIMIT); // RL6
      residue_case = arith_i.flt_coef_in_nz && arith_i.flt_coef_res_z;
      exp_unf_raw = arith_i.flt_op &&
                    (arith_i.flt_exp < -ffi_pkg::EXP_LIMIT); // RL9
      exp_unf = exp_unf_raw && !residue_case; // RL11
      fix_ovf = arith_i.fix_addsub && mag_sum; // RL12
      oob = intsys_active_i && mask_i[ffi_pkg::BIT_BOUNDS] &&
            (mem_i.write_ref || mem_i.jump_ref || mem_i.fetch_ref) &&
            ((mem_i.ref_addr_hi < mem_i.lower_bound) ||
             (mem_i.ref_addr_hi > mem_i.upper_bound)); // RL18

      set_v = '0;
      set_v[ffi_pkg::BIT_SHIFT] = shift_fault;
      set_v[ffi_pkg::BIT_DIVIDE] = div_fault;
      set_v[ffi_pkg::BIT_FIXOVF] = fix_ovf;
      set_v[ffi_pkg::BIT_EXPOVF] = exp_ovf; // RL8
      set_v[ffi_pkg::BIT_EXPUNF] = exp_unf;
      set_v[ffi_pkg::BIT_IOPAR0 +: ffi_pkg::NUM_CHAN] =
         mem_i.io_par_err; // RL23
      set_v[ffi_pkg::BIT_OPPAR] = mem_i.operand_par_err; // RL14
      set_v[ffi_pkg::BIT_INSPAR] = mem_i.instr_par_err; // RL15
      set_v[ffi_pkg::BIT_MANUAL] = manual_switch_i &&
                                   mask_i[ffi_pkg::BIT_MANUAL]; // RL16
      set_v[ffi_pkg::BIT_BOUNDS] = oob;

      // System clear and master clear wipe everything
      clr_v = {ffi_pkg::WORD_W{clear_i.intsys || master_clear_i}};
      clr_v[ffi_pkg::BIT_SHIFT] |= clear_i.arith || clear_i.shift; // RL3
      clr_v[ffi_pkg::BIT_DIVIDE] |= clear_i.arith || clear_i.divide; // RL5
      clr_v[ffi_pkg::BIT_EXPOVF] |= clear_i.arith || clear_i.expovf;
      clr_v[ffi_pkg::BIT_EXPUNF] |= clear_i.arith || clear_i.expunf;
      clr_v[ffi_pkg::BIT_FIXOVF] |= clear_i.arith || clear_i.fixovf;
      clr_v[ffi_pkg::BIT_IOPAR0 +: ffi_pkg::NUM_CHAN] |=
         {ffi_pkg::NUM_CHAN{clear_i.iopar}}; // RL13
      clr_v[ffi_pkg::BIT_OPPAR] |= clear_i.parity;
      clr_v[ffi_pkg::BIT_INSPAR] |= clear_i.parity;
      clr_v[ffi_pkg::BIT_MANUAL] |= clear_i.manual_sel ||
                                    clear_i.manual_clr; // RL17
      clr_v[ffi_pkg::BIT_BOUNDS] |= clear_i.bounds_mask_clr ||
         (clear_i.bounds_mask_set && mask_i[ffi_pkg::BIT_BOUNDS]); // RL19

      next_st = st;
      next_st.flags = (st.flags & ~clr_v) | set_v; // RL24
      // The shift unit reads this in the following cycle and holds off
      next_st.shift_inhibit = shift_fault; // RL2
      // Result kept as formed on overflow; only underflow zeroes A and Q
      next_st.regs_zero = exp_unf_raw && !residue_case; // RL7 RL10
      next_st.manual_irq = next_st.flags[ffi_pkg::BIT_MANUAL] &&
                           intsys_active_i; // RL22
      next_st.lamps.shift = next_st.flags[ffi_pkg::BIT_SHIFT]; // RL20
      next_st.lamps.divide = next_st.flags[ffi_pkg::BIT_DIVIDE];
      next_st.lamps.expovf = next_st.flags[ffi_pkg::BIT_EXPOVF];
      next_st.lamps.expunf = next_st.flags[ffi_pkg::BIT_EXPUNF];
      next_st.lamps.fixovf = next_st.flags[ffi_pkg::BIT_FIXOVF];
      next_st.lamps.oppar = next_st.flags[ffi_pkg::BIT_OPPAR];
      next_st.halt = 1'b0; // RL21
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fault_flag_register_o = st.flags;
   assign shift_inhibit_o = st.shift_inhibit;
   assign regs_zero_o = st.regs_zero;
   assign manual_irq_o = st.manual_irq;
   assign lamps_o = st.lamps;
   // Faults never stop the processor
   assign halt_o = st.halt;

   // A fault pulse and the flag it leaves, seen one cycle apart
   sequence s_dbl_fault;
      arith_i.shift_req && arith_i.shift_double &&
      arith_i.shift_count > ffi_pkg::SHIFT_MAX_DOUBLE;
   endsequence

   sequence s_shift_held;
      st.shift_inhibit && st.lamps.shift && st.flags[ffi_pkg::BIT_SHIFT];
   endsequence

   // No set source active, so a full clear must empty every flag
   sequence s_quiet_clear;
      (clear_i.intsys || master_clear_i) && !arith_i.shift_req &&
      !arith_i.fix_addsub && !arith_i.int_div && !arith_i.div_zero &&
      !arith_i.flt_div_coef_big && !arith_i.flt_op &&
      mem_i.io_par_err == '0 && !mem_i.operand_par_err &&
      !mem_i.instr_par_err && !manual_switch_i && !mem_i.write_ref &&
      !mem_i.jump_ref && !mem_i.fetch_ref;
   endsequence

   AST_SHIFT_SET: assert property (shift_fault |=> // RL1
      st.flags[ffi_pkg::BIT_SHIFT] && st.shift_inhibit)
      else $error("shift fault not recorded");

   AST_SHIFT_DBL: assert property (s_dbl_fault |=> s_shift_held) // RL1
      else $error("double shift fault not held");

   AST_SHIFT_EDGE: assert property (arith_i.shift_req && // RL1
      arith_i.shift_count == ffi_pkg::SHIFT_MAX_SINGLE |=> !st.shift_inhibit)
      else $error("shift at limit refused");

   AST_SHIFT_IDLE: assert property (!shift_fault |=> !st.shift_inhibit) // RL2
      else $error("shift held off without fault");

   AST_SHIFT_HOLD: assert property (st.flags[ffi_pkg::BIT_SHIFT] && // RL3
      !clear_i.arith && !clear_i.shift && !clear_i.intsys &&
      !master_clear_i |=> st.flags[ffi_pkg::BIT_SHIFT])
      else $error("shift flag lost");

   AST_SHIFT_CLR: assert property (clear_i.shift && !shift_fault |=> // RL3
      !st.flags[ffi_pkg::BIT_SHIFT])
      else $error("shift flag not cleared");

   AST_SYS_CLR: assert property (s_quiet_clear |=> st.flags == '0) // RL3
      else $error("system clear left flags set");

   AST_DIV_ZERO: assert property (arith_i.div_zero |=> // RL4
      st.flags[ffi_pkg::BIT_DIVIDE])
      else $error("divide by zero not flagged");

   AST_DIV_COEF: assert property (arith_i.flt_div_coef_big |=> // RL4
      st.flags[ffi_pkg::BIT_DIVIDE])
      else $error("large dividend coefficient not flagged");

   AST_DIV_QUOT: assert property (arith_i.int_div && // RL4
      arith_i.int_quot[ffi_pkg::WORD_W -: 2] == 2'h1 |=>
      st.flags[ffi_pkg::BIT_DIVIDE])
      else $error("large quotient not flagged");

   AST_DIV_HOLD: assert property (st.flags[ffi_pkg::BIT_DIVIDE] && // RL5
      !clear_i.arith && !clear_i.divide && !clear_i.intsys &&
      !master_clear_i |=> st.flags[ffi_pkg::BIT_DIVIDE])
      else $error("divide flag lost");

   AST_ARITH_CLR: assert property (clear_i.arith && !shift_fault && // RL5
      !div_fault && !exp_ovf && !exp_unf && !fix_ovf |=>
      st.flags[ffi_pkg::BIT_EXPUNF:ffi_pkg::BIT_SHIFT] == '0)
      else $error("arithmetic flags not cleared");

   AST_OVF_SET: assert property (arith_i.flt_op && // RL6
      arith_i.flt_exp > ffi_pkg::EXP_LIMIT |=> st.flags[ffi_pkg::BIT_EXPOVF])
      else $error("exponent overflow not flagged");

   AST_OVF_CLR: assert property (clear_i.expovf && !exp_ovf |=> // RL5
      !st.flags[ffi_pkg::BIT_EXPOVF])
      else $error("overflow flag not cleared");

   AST_OVF_KEEP: assert property (exp_ovf && !exp_unf_raw |=> // RL7
      !st.regs_zero)
      else $error("overflow result altered");

   AST_OVF_RESIDUE: assert property (arith_i.flt_op && // RL8
      arith_i.flt_exp > ffi_pkg::EXP_LIMIT && arith_i.flt_coef_in_nz &&
      arith_i.flt_coef_res_z |=>
      st.flags[ffi_pkg::BIT_EXPOVF] && !st.regs_zero)
      else $error("residue overflow mishandled");

   AST_UNF_SET: assert property (arith_i.flt_op && // RL9
      arith_i.flt_exp < -ffi_pkg::EXP_LIMIT && !arith_i.flt_coef_res_z |=>
      st.flags[ffi_pkg::BIT_EXPUNF] && st.regs_zero)
      else $error("exponent underflow not flagged");

   AST_UNF_CLR: assert property (clear_i.expunf && !exp_unf |=> // RL5
      !st.flags[ffi_pkg::BIT_EXPUNF])
      else $error("underflow flag not cleared");

   AST_UNF_ZERO: assert property (!(arith_i.flt_op && // RL10
      arith_i.flt_exp < -ffi_pkg::EXP_LIMIT) |=> !st.regs_zero)
      else $error("registers zeroed without underflow");

   AST_UNF_MASK: assert property (exp_unf_raw && residue_case && // RL11
      !st.flags[ffi_pkg::BIT_EXPUNF]
      |=> !st.flags[ffi_pkg::BIT_EXPUNF] && !st.regs_zero)
      else $error("masked underflow flagged");

   AST_FIX_SET: assert property (arith_i.fix_addsub && // RL12
      arith_i.fix_sum[ffi_pkg::WORD_W -: 2] == 2'h1 |=>
      st.flags[ffi_pkg::BIT_FIXOVF])
      else $error("fixed overflow not flagged");

   AST_FIX_CLR: assert property (clear_i.fixovf && !fix_ovf |=> // RL5
      !st.flags[ffi_pkg::BIT_FIXOVF])
      else $error("fixed overflow flag not cleared");

   AST_IO_MAP: assert property (mem_i.io_par_err[2] |=> // RL23
      st.flags[ffi_pkg::BIT_IOPAR0 + 2])
      else $error("channel parity bit misplaced");

   AST_IO_CLR: assert property (clear_i.iopar && // RL13
      mem_i.io_par_err == '0 |=>
      st.flags[ffi_pkg::BIT_IOPAR0 +: ffi_pkg::NUM_CHAN] == '0)
      else $error("channel parity flags not cleared");

   AST_IO_HOLD: assert property (st.flags[ffi_pkg::BIT_IOPAR0] && // RL13
      !clear_i.iopar && !clear_i.intsys && !master_clear_i |=>
      st.flags[ffi_pkg::BIT_IOPAR0])
      else $error("channel parity flag lost");

   AST_OPPAR_SET: assert property (mem_i.operand_par_err |=> // RL14
      st.flags[ffi_pkg::BIT_OPPAR])
      else $error("operand parity not flagged");

   AST_INSPAR_SET: assert property (mem_i.instr_par_err |=> // RL15
      st.flags[ffi_pkg::BIT_INSPAR])
      else $error("instruction parity not flagged");

   AST_PAR_CLR: assert property (clear_i.parity && // RL14
      !mem_i.operand_par_err && !mem_i.instr_par_err |=>
      !st.flags[ffi_pkg::BIT_OPPAR] && !st.flags[ffi_pkg::BIT_INSPAR])
      else $error("parity flags not cleared");

   AST_SET_WINS: assert property (mem_i.operand_par_err && // RL24
      clear_i.intsys |=> st.flags[ffi_pkg::BIT_OPPAR])
      else $error("set lost to clear");

   AST_MANUAL: assert property (manual_switch_i && // RL16
      !mask_i[ffi_pkg::BIT_MANUAL] && !st.flags[ffi_pkg::BIT_MANUAL]
      |=> !st.flags[ffi_pkg::BIT_MANUAL])
      else $error("unmasked manual interrupt set");

   AST_MANUAL_SET: assert property (manual_switch_i && // RL16
      mask_i[ffi_pkg::BIT_MANUAL] |=> st.flags[ffi_pkg::BIT_MANUAL])
      else $error("masked manual interrupt lost");

   AST_MANUAL_CLR: assert property ((clear_i.manual_sel || // RL17
      clear_i.manual_clr) && !manual_switch_i |=>
      !st.flags[ffi_pkg::BIT_MANUAL])
      else $error("manual flag not cleared");

   AST_BOUNDS_SET: assert property (intsys_active_i && // RL18
      mask_i[ffi_pkg::BIT_BOUNDS] && mem_i.write_ref &&
      mem_i.ref_addr_hi < mem_i.lower_bound |=>
      st.flags[ffi_pkg::BIT_BOUNDS])
      else $error("out of bounds write not flagged");

   AST_BOUNDS_OFF: assert property (!intsys_active_i && // RL18
      !st.flags[ffi_pkg::BIT_BOUNDS] |=> !st.flags[ffi_pkg::BIT_BOUNDS])
      else $error("bounds flagged with system inactive");

   AST_BOUNDS_CLR: assert property (clear_i.bounds_mask_clr && !oob // RL19
      |=> !st.flags[ffi_pkg::BIT_BOUNDS])
      else $error("bounds flag not cleared");

   AST_BOUNDS_AGAIN: assert property (clear_i.bounds_mask_set && // RL19
      mask_i[ffi_pkg::BIT_BOUNDS] && !oob |=>
      !st.flags[ffi_pkg::BIT_BOUNDS])
      else $error("redundant mask set kept bounds flag");

   AST_LAMPS: assert property (st.lamps == { // RL20
      st.flags[ffi_pkg::BIT_SHIFT], st.flags[ffi_pkg::BIT_DIVIDE],
      st.flags[ffi_pkg::BIT_EXPOVF], st.flags[ffi_pkg::BIT_EXPUNF],
      st.flags[ffi_pkg::BIT_FIXOVF], st.flags[ffi_pkg::BIT_OPPAR]})
      else $error("console lamp disagrees with flag");

   AST_NO_HALT: assert property (!st.halt) // RL21
      else $error("processor halted on fault");

   AST_MIRQ: assert property (st.manual_irq |-> // RL22
      st.flags[ffi_pkg::BIT_MANUAL])
      else $error("manual interrupt without flag");

   AST_MIRQ_OFF: assert property (!intsys_active_i |=> // RL22
      !st.manual_irq)
      else $error("manual interrupt with system inactive");
endmodule
`default_nettype wire

// ==== testbench/ffi_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ffi_far_model (
   // Clock
   input wire logic clk_i,
   // Request from the bench
   input wire logic [3:0] kind_i,
   input wire logic [48:0] val_i,
   // Reports into the flag block
   output ffi_pkg::ffi_arith_t arith_o,
   output ffi_pkg::ffi_mem_t mem_o,
   output logic switch_o
);
   logic [7:0] churn = 8'h00;
   // Unqualified fields wander, so a stale value is never trusted
   always @(posedge clk_i) begin
      churn <= churn + 8'h5b;
   end
   always_comb begin
      arith_o = '0;
      mem_o = '0;
      arith_o.shift_count = churn;
      arith_o.flt_exp = {4'h0, churn};
      mem_o.ref_addr_hi = churn;
      mem_o.lower_bound = 8'h10;
      mem_o.upper_bound = 8'h80;
      switch_o = (kind_i == 4'hc);
      case (kind_i)
         4'h1, 4'h2: begin
            arith_o.shift_req = 1'b1;
            arith_o.shift_double = kind_i[1];
            arith_o.shift_count = val_i[7:0];
         end
         4'h3: begin
            arith_o.fix_addsub = 1'b1;
            arith_o.fix_sum = val_i;
         end
         4'h4: begin
            arith_o.int_div = 1'b1;
            arith_o.int_quot = val_i;
         end
         4'h5: arith_o.div_zero = 1'b1;
         4'h6: arith_o.flt_div_coef_big = 1'b1;
         4'h7: begin
            arith_o.flt_op = 1'b1;
            arith_o.flt_exp = val_i[11:0];
            arith_o.flt_coef_in_nz = val_i[12];
            arith_o.flt_coef_res_z = val_i[13];
         end
         4'h8: mem_o.io_par_err[val_i[1:0]] = 1'b1;
         4'h9: mem_o.operand_par_err = 1'b1;
         4'ha: mem_o.instr_par_err = 1'b1;
         4'hb: begin
            mem_o.write_ref = (val_i[9:8] == 2'h1);
            mem_o.jump_ref = (val_i[9:8] == 2'h2);
            mem_o.fetch_ref = (val_i[9:8] == 2'h3);
            mem_o.ref_addr_hi = val_i[7:0];
         end
         default: switch_o = switch_o;
      endcase
   end
endmodule
`default_nettype wire

// ==== testbench/ffi_flags_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module ffi_flags_tb;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic mc = 1'b0;
   logic sys = 1'b1;
   logic [47:0] msk = 48'h0c0000000000;
   logic [3:0] kind = 4'h0;
   logic [48:0] val = 49'h0;
   ffi_pkg::ffi_clear_t clr = '0;
   ffi_pkg::ffi_arith_t ar;
   ffi_pkg::ffi_mem_t mm;
   ffi_pkg::ffi_lamps_t lamps;
   logic [47:0] flags;
   logic sw, inh, rz, mirq, halt;
   int n_errors = 0;
   int num_checks = 0;
   int seed = 80516;
   int cyc = 0;
   always #50 clk_i = ~clk_i;
   ffi_far_model ffi_far_model_i (.clk_i(clk_i), .kind_i(kind), .val_i(val),
      .arith_o(ar), .mem_o(mm), .switch_o(sw));
   ffi_flags ffi_flags_i (.clk_i(clk_i), .resetn_i(resetn_i),
      .master_clear_i(mc), .manual_switch_i(sw), .intsys_active_i(sys),
      .mask_i(msk), .arith_i(ar), .mem_i(mm), .clear_i(clr),
      .fault_flag_register_o(flags), .shift_inhibit_o(inh),
      .regs_zero_o(rz), .manual_irq_o(mirq), .halt_o(halt), .lamps_o(lamps));
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Ceiling sized well above the roughly 890 cycles the run needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         close_out();
      end
   end
   task automatic chkv(input logic [47:0] g, input logic [47:0] e);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t vector got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t bit got %b exp %b", $time, g, e);
      end
   endtask
   function automatic logic big(input logic [48:0] v);
      return $signed(v) >= 49'sh800000000000 ||
         $signed(v) <= -49'sh800000000000;
   endfunction
   function automatic logic [47:0] exp_f(input int k, input logic [48:0] v);
      logic [47:0] e;
      logic signed [11:0] x;
      e = '0;
      x = v[11:0];
      case (k)
         1: e[1] = v[7:0] > 8'h30;
         2: e[1] = v[7:0] > 8'h60;
         3: e[3] = big(v);
         4: e[2] = big(v);
         5, 6: e[2] = 1'b1;
         7: begin
            e[4] = x > 12'sh3ff;
            e[5] = x < -12'sh3ff && !(v[12] && v[13]);
         end
         8: e[20 + v[1:0]] = 1'b1;
         9: e[45] = 1'b1;
         10: e[46] = 1'b1;
         11: e[42] = sys && msk[42] && v[9:8] != 2'h0 &&
            (v[7:0] < 8'h10 || v[7:0] > 8'h80);
         12: e[43] = msk[43];
         default: e = '0;
      endcase
      return e;
   endfunction
   // Zero clear vector means the console master clear is used instead
   task automatic run(input int k, input logic [48:0] v,
         input ffi_pkg::ffi_clear_t c);
      logic [47:0] e;
      @(posedge clk_i);
      e = exp_f(k, v);
      kind <= k[3:0];
      val <= v;
      @(posedge clk_i);
      kind <= 4'h0;
      @(negedge clk_i);
      chkv(flags, e);
      chkb(inh, e[1]);
      chkb(rz, e[5]);
      chkb(mirq, e[43] && sys);
      chkb(halt, 1'b0);
      chkv({42'h0, lamps}, {42'h0, e[1], e[2], e[4], e[5], e[3], e[45]});
      @(posedge clk_i);
      clr <= c;
      mc <= (c == '0);
      @(posedge clk_i);
      clr <= '0;
      mc <= 1'b0;
      @(negedge clk_i);
      chkv(flags, 48'h0);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chkv(flags, ffi_pkg::FLAGS_RESET);
      run(1, 49'h30, 13'h800);
      run(1, 49'h31, 13'h800);
      run(2, 49'h60, 13'h1000);
      run(2, 49'h61, 13'h1000);
      run(3, 49'h7fffffffffff, 13'h080);
      run(3, 49'h800000000000, 13'h080);
      run(3, 49'h1800000000000, 13'h1000);
      run(4, 49'h800000000000, 13'h400);
      run(5, 49'h0, 13'h400);
      run(6, 49'h0, 13'h1000);
      run(7, 49'h3ff, 13'h200);
      run(7, 49'h400, 13'h200);
      run(7, 49'h3400, 13'h1000);
      run(7, 49'hc00, 13'h100);
      run(7, 49'hc01, 13'h100);
      run(7, 49'h3c00, 13'h100);
      for (int n = 0; n < 4; n++) run(8, 49'(n), 13'h040);
      run(9, 49'h0, 13'h020);
      run(10, 49'h0, 13'h020);
      run(12, 49'h0, 13'h010);
      run(12, 49'h0, 13'h008);
      run(11, 49'h105, 13'h004);
      run(11, 49'h381, 13'h002);
      run(11, 49'h240, 13'h001);
      @(posedge clk_i);
      kind <= 4'h9;
      clr <= 13'h020;
      @(posedge clk_i);
      kind <= 4'h0;
      clr <= '0;
      @(negedge clk_i);
      chkb(flags[45], 1'b1);
      @(posedge clk_i);
      clr <= 13'h020;
      msk <= 48'h0;
      @(posedge clk_i);
      clr <= '0;
      @(negedge clk_i);
      chkv(flags, 48'h0);
      run(12, 49'h0, 13'h001);
      run(11, 49'h105, 13'h001);
      @(posedge clk_i);
      msk <= 48'h0c0000000000;
      sys <= 1'b0;
      run(11, 49'h105, 13'h000);
      for (int i = 0; i < 150; i++) begin
         @(posedge clk_i);
         msk[43:42] <= 2'($random(seed));
         sys <= 1'($random(seed));
         run(1 + ($unsigned($random(seed)) % 12),
            {17'($random(seed)), 32'($random(seed))},
            (i % 2 == 0) ? 13'h001 : 13'h000);
      end
      close_out();
   end
endmodule
`default_nettype wire
